// file: verilog/sacc_ctrl.sv
// Top of the conversion control: channel latch, sequencer, result buffer.
// Assumes all pins synchronous to core_clk; conv_clk is the sampled
// conversion clock whose edges pace the sequence.
`timescale 1ns/1ps
module sacc_ctrl
    import sacc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Conversion clock and control pins
    input wire logic conv_clk,
    input wire logic start,
    input wire logic ale,
    input wire logic out_en,
    // Channel select pins
    input wire logic [SEL_W-1:0] channel_select_inputs,
    // Analog front end
    input wire logic cmp_in,
    output logic [NUM_CH-1:0] chan_onehot,
    output logic sample_en,
    output logic autozero,
    output logic cap_phase,
    output logic [RES_W-1:0] dac_code,
    // Result and status
    output logic eoc,
    output logic [RES_W-1:0] result_bus_out,
    output logic result_bus_oe
);
    sacc_sar_if sif();

    // Approximation register
    sacc_sar u_sar (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sif(sif)
    );

    logic clk_q; // Previous conversion clock level
    logic ale_q; // Previous strobe level
    logic clk_rise; // Conversion clock rising
    logic clk_fall; // Conversion clock falling
    logic ale_rise; // Strobe rising
    logic [SEL_W-1:0] chan_lat; // Latched channel
    logic [SEL_W-1:0] next_chan_lat;
    logic [NUM_CH-1:0] next_onehot;
    sacc_state_t state; // Sequencer state
    sacc_state_t next_state;
    logic next_eoc;
    logic next_sample_en;
    logic next_autozero;
    logic [RES_W-1:0] result; // Double-buffered result
    logic [RES_W-1:0] next_result;
    logic seq_clear; // Clear approximation
    logic seq_step; // Commit a decision

    // Edge detection on sampled pins
    assign clk_rise = conv_clk && !clk_q;
    assign clk_fall = !conv_clk && clk_q;
    assign ale_rise = ale && !ale_q;

    // Pin history
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clk_q <= LOW;
            ale_q <= LOW;
        end else begin
            clk_q <= conv_clk;
            ale_q <= ale;
        end
    end

    // Channel latch and decoder next values
    always_comb begin
        next_chan_lat = chan_lat;
        if (ale_rise) begin
            next_chan_lat = channel_select_inputs;
        end
        next_onehot = CH_ONE << chan_lat;
    end

    // Channel registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            chan_lat <= SEL_ZERO;
            chan_onehot <= CH_ONE;
        end else begin
            chan_lat <= next_chan_lat;
            chan_onehot <= next_onehot;
        end
    end

    // Sequencer next values
    always_comb begin
        next_state = state;
        next_eoc = eoc;
        next_sample_en = LOW;
        next_autozero = LOW;
        next_result = result;
        seq_clear = LOW;
        seq_step = LOW;
        if (start) begin
            // Held in reset; running conversion dropped, flag untouched
            next_state = ST_HOLD;
            seq_clear = HIGH;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_HOLD: begin
                    // Start has fallen: wait for the next rising edge
                    next_state = ST_ARM;
                end
                ST_ARM: begin
                    if (clk_rise) begin
                        next_state = ST_SAMPLE;
                        next_sample_en = HIGH;
                        next_autozero = HIGH;
                    end
                end
                ST_SAMPLE: begin
                    next_sample_en = HIGH;
                    next_autozero = HIGH;
                    if (clk_fall) begin
                        // Input held, decisions begin
                        next_state = ST_CONV;
                        next_sample_en = LOW;
                        next_autozero = LOW;
                        next_eoc = LOW;
                    end
                end
                ST_CONV: begin
                    if (clk_rise) begin
                        seq_step = HIGH;
                        if (sif.mask == LSB_MASK) begin
                            next_state = ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    if (clk_rise) begin
                        next_result = sif.code;
                        next_eoc = HIGH;
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // Sequencer registers; result holds its reset value until a completion
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            eoc <= HIGH;
            sample_en <= LOW;
            autozero <= LOW;
            result <= RES_ZERO;
        end else begin
            state <= next_state;
            eoc <= next_eoc;
            sample_en <= next_sample_en;
            autozero <= next_autozero;
            result <= next_result;
        end
    end

    // Approximation controls
    assign sif.clear = seq_clear;
    assign sif.step = seq_step;
    assign sif.cmp = cmp_in;

    // Registered analog and bus outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dac_code <= MSB_MASK;
            cap_phase <= HIGH;
            result_bus_out <= RES_ZERO;
            result_bus_oe <= LOW;
        end else begin
            dac_code <= sif.trial;
            cap_phase <= |(sif.mask & CAP_MASK);
            result_bus_out <= result;
            result_bus_oe <= out_en;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Strobe edge latches the select pins
    property p_latch;
        ale_rise |=> chan_lat == $past(channel_select_inputs);
    endproperty
    a_latch: assert property (p_latch) else $error("channel not latched");

    // Selection holds between strobe edges
    property p_hold_sel;
        !ale_rise |=> $stable(chan_lat);
    endproperty
    a_hold_sel: assert property (p_hold_sel) else $error("channel changed without strobe");

    // One-hot decode of the latched select
    property p_decode;
        1'b1 |=> chan_onehot == (CH_ONE << $past(chan_lat));
    endproperty
    a_decode: assert property (p_decode) else $error("channel decode wrong");

    // Start high holds the sequencer in reset
    property p_start_hold;
        start |=> state == ST_HOLD && !sample_en;
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start did not reset");

    // Sampling opens on the first rising edge after start falls
    property p_window;
        state == ST_ARM && clk_rise && !start |=> sample_en && autozero;
    endproperty
    a_window: assert property (p_window) else $error("sampling window missing");

    // Flag falls when sampling ends
    property p_eoc_fall;
        state == ST_SAMPLE && clk_fall && !start |=> !eoc && state == ST_CONV;
    endproperty
    a_eoc_fall: assert property (p_eoc_fall) else $error("end flag did not fall");

    // Completion loads the result and raises the flag
    property p_load;
        state == ST_LOAD && clk_rise && !start |=> eoc && result == $past(sif.code);
    endproperty
    a_load: assert property (p_load) else $error("result not loaded");

    // Result only changes on completion
    property p_keep;
        !(state == ST_LOAD && clk_rise && !start) |=> $stable(result);
    endproperty
    a_keep: assert property (p_keep) else $error("result changed early");

    // Abort never raises the flag
    property p_abort;
        start && !eoc |=> !eoc;
    endproperty
    a_abort: assert property (p_abort) else $error("flag rose on abort");

    // Bus enable follows output enable
    property p_oe;
        1'b1 |=> result_bus_oe == $past(out_en) && result_bus_out == $past(result);
    endproperty
    a_oe: assert property (p_oe) else $error("bus enable wrong");

    // Offset cancel runs whenever the sampling window opens
    property p_cancel;
        $rose(sample_en) |-> autozero;
    endproperty
    a_cancel: assert property (p_cancel) else $error("offset cancel missing in window");

    // Upper nibble trials use the capacitor section
    property p_cap_upper;
        |(sif.mask & CAP_MASK) |=> cap_phase;
    endproperty
    a_cap_upper: assert property (p_cap_upper) else $error("upper trial not on capacitor section");

    // Lower nibble trials use the resistor section
    property p_res_lower;
        sif.mask != RES_ZERO && !(|(sif.mask & CAP_MASK)) |=> !cap_phase;
    endproperty
    a_res_lower: assert property (p_res_lower) else $error("lower trial not on resistor section");

    // At most one decision per conversion clock rise
    property p_step_once;
        seq_step |=> !seq_step;
    endproperty
    a_step_once: assert property (p_step_once) else $error("two decisions in a row");

    // Start clears the approximation register
    property p_restart_clear;
        start |=> sif.code == RES_ZERO && sif.mask == MSB_MASK;
    endproperty
    a_restart_clear: assert property (p_restart_clear) else $error("start did not clear decisions");

    // Flag only rises out of the load step
    property p_eoc_rise;
        $rose(eoc) |-> $past(state) == ST_LOAD;
    endproperty
    a_eoc_rise: assert property (p_eoc_rise) else $error("end flag rose outside load");
endmodule

// file: verilog/sacc_pkg.sv
// Package for the converter conversion control block.
// Assumes one 10 MHz core clock and synchronous active-high reset.
package sacc_pkg;
    // Result and channel widths
    localparam int RES_W = 8;
    localparam int SEL_W = 3;
    localparam int NUM_CH = 8;
    // Successive-approximation constants
    localparam logic [RES_W-1:0] MSB_MASK = 8'h80;
    localparam logic [RES_W-1:0] LSB_MASK = 8'h01;
    localparam logic [RES_W-1:0] CAP_MASK = 8'hF0;
    localparam logic [RES_W-1:0] RES_ZERO = 8'h00;
    localparam logic [NUM_CH-1:0] CH_ONE = 8'h01;
    localparam logic [SEL_W-1:0] SEL_ZERO = 3'h0;
    localparam logic LOW = 1'b0;
    localparam logic HIGH = 1'b1;
    // Sequencer states, Gray coded along the conversion path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_HOLD = 3'h1,
        ST_ARM = 3'h3,
        ST_SAMPLE = 3'h2,
        ST_CONV = 3'h6,
        ST_LOAD = 3'h7
    } sacc_state_t;
endpackage

// file: verilog/sacc_sar_if.sv
// Interface between the sequencer and the approximation register.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
interface sacc_sar_if;
    import sacc_pkg::*;
    logic clear; // Restart the approximation
    logic step; // Commit one bit decision
    logic cmp; // Comparator decision
    logic [RES_W-1:0] code; // Decided bits so far
    logic [RES_W-1:0] mask; // Bit under trial
    logic [RES_W-1:0] trial; // Level under trial
    modport seq (output clear, output step, output cmp, input code, input mask, input trial);
    modport sar (input clear, input step, input cmp, output code, output mask, output trial);
endinterface

// file: verilog/sacc_sar.sv
// Successive-approximation register: one bit decision per step.
// Assumes the sequencer raises step once per conversion clock period.
`timescale 1ns/1ps
module sacc_sar
    import sacc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Sequencer side
    sacc_sar_if.sar sif
);
    logic [RES_W-1:0] code; // Stored decisions
    logic [RES_W-1:0] mask; // Current trial bit
    logic [RES_W-1:0] next_code;
    logic [RES_W-1:0] next_mask;
    logic [RES_W-1:0] bit_next; // Per-bit next value

    // Per-bit decision update
    genvar gi;
    generate
        for (gi = 0; gi < RES_W; gi++) begin : g_bit
            assign bit_next[gi] = (sif.step && mask[gi]) ? sif.cmp : code[gi];
        end
    endgenerate

    // Next decisions and trial bit
    always_comb begin
        next_code = code;
        next_mask = mask;
        if (sif.clear) begin
            next_code = RES_ZERO;
            next_mask = MSB_MASK;
        end else if (sif.step) begin
            next_code = bit_next;
            next_mask = mask >> 1;
        end
    end

    // Register the state
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            code <= RES_ZERO;
            mask <= MSB_MASK;
        end else begin
            code <= next_code;
            mask <= next_mask;
        end
    end

    // Outputs towards the sequencer
    assign sif.code = code;
    assign sif.mask = mask;
    assign sif.trial = code | mask;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // One bit decided per step
    property p_one_bit;
        sif.step && !sif.clear |=> mask == ($past(mask) >> 1);
    endproperty
    a_one_bit: assert property (p_one_bit) else $error("trial bit did not advance");
endmodule

// file: testbench/sacc_analog_model.sv
// Comparator stand-in for the analog side of the converter.
// Assumes dac_code is the trial level and level the held input sample.
`timescale 1ns/1ps
module sacc_analog_model
    import sacc_pkg::*;
(
    // Trial level from the block
    input wire logic [RES_W-1:0] dac_code,
    // Input sample, as an unsigned code
    input wire logic [RES_W-1:0] level,
    // Decision back to the block
    output logic cmp_in
);
    // Keep the trial bit while the input is at or above the trial level
    assign cmp_in = (level >= dac_code);
endmodule

// file: testbench/sacc_ctrl_tb_top.sv
// Self-checking bench for the conversion control block.
// Assumes a 10 MHz core clock; conv_clk is made here at 1/8 of it.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module sacc_ctrl_tb_top;
    import sacc_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic conv_clk = 1'b0;
    logic start = 1'b0;
    logic ale = 1'b0;
    logic out_en = 1'b1;
    logic [SEL_W-1:0] channel_select_inputs = SEL_ZERO;
    logic [RES_W-1:0] level = 8'hA5; // Analog sample as a code
    logic cmp_in;
    logic [NUM_CH-1:0] chan_onehot;
    logic sample_en, autozero, cap_phase, eoc, result_bus_oe;
    logic [RES_W-1:0] dac_code, result_bus_out;
    int n_mismatch = 0;
    int n_compared = 0;
    // Clock at 100 ns period
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    // Conversion clock: each level lasts 4 core cycles
    always @(negedge core_clk) begin
        repeat (3) @(negedge core_clk);
        conv_clk <= ~conv_clk;
    end
    sacc_ctrl dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .conv_clk(conv_clk), .start(start),
        .ale(ale), .out_en(out_en), .channel_select_inputs(channel_select_inputs), .cmp_in(cmp_in),
        .chan_onehot(chan_onehot), .sample_en(sample_en), .autozero(autozero), .cap_phase(cap_phase),
        .dac_code(dac_code), .eoc(eoc), .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe));
    sacc_analog_model model_u (.dac_code(dac_code), .level(level), .cmp_in(cmp_in));
    // Wait, bounded, for the end flag to reach a level
    task automatic wait_eoc(input logic v);
        int i;
        for (i = 0; i < 300 && eoc !== v; i++) @(negedge core_clk);
        `CHK("eoc wait", v, eoc)
    endtask
    // One cycle start pulse
    task automatic pulse_start();
        @(negedge core_clk) start = 1'b1;
        @(negedge core_clk) start = 1'b0;
    endtask
    // Strobe every select code and check the decoded channel
    task automatic t_channels();
        int n;
        for (n = 0; n < NUM_CH; n++) begin
            @(negedge core_clk) channel_select_inputs = n[SEL_W-1:0];
            ale = 1'b1;
            @(negedge core_clk) ale = 1'b0;
            channel_select_inputs = ~n[SEL_W-1:0];
            repeat (3) @(negedge core_clk);
            `CHK("chan_onehot", CH_ONE << n, chan_onehot)
        end
        $display("test channels done");
    endtask
    // Full conversion: old data held, nine conv_clk rises, new data out
    task automatic t_convert(input logic [RES_W-1:0] v);
        logic [RES_W-1:0] old;
        logic prev;
        int rises;
        old = result_bus_out;
        level = v;
        pulse_start();
        wait_eoc(1'b0);
        `CHK("old result held", old, result_bus_out)
        `CHK("first trial", MSB_MASK, dac_code)
        rises = 0;
        prev = conv_clk;
        while (eoc !== 1'b1 && rises < 20) begin
            @(negedge core_clk);
            if (conv_clk && !prev) begin
                rises++;
                if (rises == 4) `CHK("upper nibble phase", 1'b1, cap_phase)
                if (rises == 5) `CHK("lower nibble phase", 1'b0, cap_phase)
            end
            prev = conv_clk;
        end
        `CHK("conv_clk rises", 9, rises)
        repeat (2) @(negedge core_clk);
        `CHK("result", v, result_bus_out)
        `CHK("final trial", v, dac_code)
        $display("test convert %h done", v);
    endtask
    // Acquisition window: sampling and offset cancel together
    task automatic t_sample();
        int i;
        pulse_start();
        for (i = 0; i < 100 && sample_en !== 1'b1; i++) @(negedge core_clk);
        `CHK("sample_en", 1'b1, sample_en)
        `CHK("autozero", 1'b1, autozero)
        wait_eoc(1'b0);
        `CHK("sample end", 1'b0, sample_en)
        wait_eoc(1'b1);
        $display("test sample done");
    endtask
    // Abort mid-conversion with start held high, then restart
    task automatic t_abort();
        logic [RES_W-1:0] old;
        old = result_bus_out;
        level = 8'h3C;
        pulse_start();
        wait_eoc(1'b0);
        repeat (20) @(negedge core_clk);
        start = 1'b1;
        repeat (60) @(negedge core_clk);
        `CHK("held sample_en", 1'b0, sample_en)
        `CHK("abort eoc", 1'b0, eoc)
        `CHK("abort result", old, result_bus_out)
        start = 1'b0;
        wait_eoc(1'b1);
        repeat (2) @(negedge core_clk);
        `CHK("restart result", 8'h3C, result_bus_out)
        $display("test abort done");
    endtask
    // Output enable floats and restores the bus
    task automatic t_out_en();
        @(negedge core_clk) out_en = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK("oe off", 1'b0, result_bus_oe)
        out_en = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK("oe on", 1'b1, result_bus_oe)
        $display("test out_en done");
    endtask
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        #3000000;
        n_mismatch++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        `CHK("reset eoc", 1'b1, eoc)
        `CHK("reset result", RES_ZERO, result_bus_out)
        t_channels();
        t_convert(8'hA5);
        t_convert(8'hFF);
        t_convert(8'h00);
        t_sample();
        t_abort();
        t_out_en();
        tally_and_finish();
    end
endmodule
